// [rtl/toc_pkg.sv]
// constants, field layouts and carrier types of the output compare timer
// assumes one 20 MHz clock and an Avalon-MM slave with word index addressing
//
// Notes on behaviour
// - shared interrupt pin works as plain port, forced cutoff input or interrupt input.
// - reading the count register returns the live counter and disturbs nothing.
// - writing the count register loads the counter.
// - each of the four pins separately may or may not produce compare output.
// - on a match an enabled pin goes low, high or toggles per its action.
// - each pin holds its initial level from start until its first match.
// - counter returns to zero on overflow or on compare A match, software's choice.
// - with all pins disabled the counter still counts and matches internally.
// - control bits 0 to 3 give initial levels of pins A to D, 1 high.
// - bits 6 to 4 pick the count source among eight documented sources.
// - control bit 7 set clears the counter on compare A match, else free runs.
// - writing the control register drives enabled pins to their initial levels at once.
// - compare A and B serve pins A and B; C and D serve C, D unbuffered.
// - buffered C or D holds next A or B value and its pin is released.
// - period is 65536 source ticks free running, compare A plus one when clearing.
// - writing run 1 starts counting; writing 0 stops, pins and counter hold.
// - with stop at match set, compare A match stops the counter, pins keep levels.
// - a match on compare A or B, or on C or D while unbuffered, or an overflow, raises a request.
package toc_pkg;
    // register word indices, byte address is four times the index
    localparam logic [9:0] IDX_MODE = 10'h120;
    localparam logic [9:0] IDX_CTRL1 = 10'h121;
    localparam logic [9:0] IDX_IOCTL0 = 10'h124;
    localparam logic [9:0] IDX_IOCTL1 = 10'h125;
    localparam logic [9:0] IDX_COUNT = 10'h126;
    localparam logic [9:0] IDX_STATUS = 10'h127;
    localparam logic [9:0] IDX_CMP_A = 10'h128;
    localparam logic [9:0] IDX_CMP_B = 10'h129;
    localparam logic [9:0] IDX_CMP_C = 10'h12A;
    localparam logic [9:0] IDX_CMP_D = 10'h12B;
    localparam logic [9:0] IDX_CTRL2 = 10'h130;
    // field positions
    localparam int MODE_BUF_C = 5;
    localparam int MODE_BUF_D = 6;
    localparam int MODE_RUN = 7;
    localparam int CTRL1_SRC_LO = 4;
    localparam int CTRL1_CLEAR = 7;
    localparam int CTRL2_STOP = 5;
    localparam int IOCTL_LO_ACT = 0;
    localparam int IOCTL_HI_ACT = 4;
    // reset values
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_CTRL1 = 8'h00;
    localparam logic [7:0] RST_IOCTL = 8'h88;
    localparam logic [7:0] RST_CTRL2 = 8'h00;
    localparam logic [7:0] IOCTL0_RD_ONE = 8'h80;
    localparam logic [15:0] RST_CMP = 16'hFFFF;
    localparam logic [15:0] CNT_TOP = 16'hFFFF;
    localparam logic [4:0] PRE_DIV32 = 5'h1F;

    typedef enum logic [2:0] {
        SRC_DIV1 = 3'h0,
        SRC_DIV2 = 3'h1,
        SRC_DIV4 = 3'h2,
        SRC_DIV8 = 3'h3,
        SRC_DIV32 = 3'h4,
        SRC_EXT = 3'h5,
        SRC_OSC40 = 3'h6,
        SRC_FAST = 3'h7
    } toc_src_e;

    typedef enum logic [1:0] {
        ACT_NONE = 2'h0,
        ACT_LOW = 2'h1,
        ACT_HIGH = 2'h2,
        ACT_TOGGLE = 2'h3
    } toc_act_e;

    typedef enum logic [1:0] {
        INTF_PORT = 2'h0,
        INTF_CUTOFF = 2'h1,
        INTF_IRQ = 2'h2
    } toc_intf_e;

    typedef struct packed {
        logic [3:0] level;
        logic [3:0] oe;
    } toc_wave_s;

    typedef struct packed {
        logic [3:0] match;
        logic ovf;
    } toc_evt_s;
endpackage

// [rtl/toc_top.sv]
// output compare timer: 16-bit counter, four compare registers, four wave pins
// assumes Avalon-MM master on i_clk; pin and oscillator inputs are asynchronous
module toc_top
    import toc_pkg::*;
(
    input wire logic i_clk, // 20 MHz
    input wire logic i_rst_b, // async reset, low
    input wire logic [9:0] i_avs_address, // word index
    input wire logic i_avs_read, // read request
    input wire logic i_avs_write, // write request
    input wire logic [3:0] i_avs_byteenable, // byte lanes
    input wire logic [31:0] i_avs_writedata, // write data
    output logic [31:0] o_avs_readdata, // read data
    output logic o_avs_waitrequest, // stall
    input wire logic i_ext_count_clock_pin, // external count source
    input wire logic i_osc_40mhz_clock, // on-chip oscillator
    input wire logic i_fast_osc_clock, // fast on-chip oscillator
    input wire logic i_int_pin_b, // shared interrupt pin, low active
    output toc_wave_s o_wave, // wave pin levels and enables
    output toc_evt_s o_evt, // one-cycle request pulses
    output logic o_int_req // pin interrupt pulse
);
    // ************************************************************
    // synchronisers
    // ************************************************************
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] sync3_reg;
    wire logic [3:0] pin_raw = {i_int_pin_b, i_fast_osc_clock, i_osc_40mhz_clock, i_ext_count_clock_pin};
    wire logic [2:0] src_rise = sync2_reg[2:0] & ~sync3_reg[2:0];

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_reg <= 4'hF;
            sync2_reg <= 4'hF;
            sync3_reg <= 4'hF;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // ************************************************************
    // register bus
    // ************************************************************
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [7:0] mode_reg;
    logic [7:0] ctrl1_reg;
    logic [7:0] ctrl2_reg;
    logic [7:0] ioctl0_reg;
    logic [7:0] ioctl1_reg;
    logic [15:0] cnt_reg;
    logic [15:0] cmp_reg [4];
    logic [4:0] sts_reg;
    logic [3:0] level_reg;
    logic [4:0] pre_reg;
    toc_evt_s evt_reg;
    logic int_req_reg;

    wire logic wr_go = i_avs_write & ack_reg;
    wire logic be0 = i_avs_byteenable[0];
    wire logic be1 = i_avs_byteenable[1];
    wire logic [7:0] wd8 = i_avs_writedata[7:0];
    wire logic [15:0] wd16 = i_avs_writedata[15:0];
    wire logic wr_mode = wr_go & be0 & (i_avs_address == IDX_MODE);
    wire logic wr_ctrl1 = wr_go & be0 & (i_avs_address == IDX_CTRL1);
    wire logic wr_ctrl2 = wr_go & be0 & (i_avs_address == IDX_CTRL2);
    wire logic wr_io0 = wr_go & be0 & (i_avs_address == IDX_IOCTL0);
    wire logic wr_io1 = wr_go & be0 & (i_avs_address == IDX_IOCTL1);
    wire logic wr_sts = wr_go & be0 & (i_avs_address == IDX_STATUS);
    wire logic wr_cnt = wr_go & (be0 | be1) & (i_avs_address == IDX_COUNT);
    wire logic [3:0] wr_cmp = {4{wr_go & (be0 | be1) & (i_avs_address[9:2] == IDX_CMP_A[9:2])}}
        & (4'h1 << i_avs_address[1:0]);

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (i_avs_address)
            IDX_MODE: rd_mux[7:0] = mode_reg;
            IDX_CTRL1: rd_mux[7:0] = ctrl1_reg;
            IDX_CTRL2: rd_mux[7:0] = ctrl2_reg;
            IDX_IOCTL0: rd_mux[7:0] = ioctl0_reg | IOCTL0_RD_ONE;
            IDX_IOCTL1: rd_mux[7:0] = ioctl1_reg;
            IDX_STATUS: rd_mux[4:0] = sts_reg;
            IDX_COUNT: rd_mux[15:0] = cnt_reg;
            IDX_CMP_A: rd_mux[15:0] = cmp_reg[0];
            IDX_CMP_B: rd_mux[15:0] = cmp_reg[1];
            IDX_CMP_C: rd_mux[15:0] = cmp_reg[2];
            IDX_CMP_D: rd_mux[15:0] = cmp_reg[3];
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
    assign o_avs_readdata = rdata_reg;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
            if (i_avs_read & ~ack_reg) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // ************************************************************
    // count source and compare
    // ************************************************************
    wire logic run = mode_reg[MODE_RUN];
    wire logic buf_c = mode_reg[MODE_BUF_C];
    wire logic buf_d = mode_reg[MODE_BUF_D];
    wire logic [1:0] buf_on = {buf_d, buf_c};
    wire logic clear_on_a = ctrl1_reg[CTRL1_CLEAR];
    wire logic stop_at_match = ctrl2_reg[CTRL2_STOP];
    wire toc_src_e src_sel = toc_src_e'(ctrl1_reg[CTRL1_SRC_LO +: 3]);
    wire toc_intf_e int_func = toc_intf_e'(ctrl2_reg[1:0]);

    logic tick;
    always_comb begin
        case (src_sel)
            SRC_DIV1: tick = 1'b1;
            SRC_DIV2: tick = pre_reg[0];
            SRC_DIV4: tick = &pre_reg[1:0];
            SRC_DIV8: tick = &pre_reg[2:0];
            SRC_DIV32: tick = (pre_reg == PRE_DIV32);
            SRC_EXT: tick = src_rise[0];
            SRC_OSC40: tick = src_rise[1];
            SRC_FAST: tick = src_rise[2];
            default: tick = 1'b0;
        endcase
    end

    wire logic tick_run = tick & run;
    // buffered C or D only feed the next A or B value
    wire logic [3:0] match = {cnt_reg == cmp_reg[3] && !buf_d, cnt_reg == cmp_reg[2] && !buf_c,
        cnt_reg == cmp_reg[1], cnt_reg == cmp_reg[0]};
    wire logic stop_hit = tick_run & match[0] & stop_at_match;
    wire logic [1:0] act [4] = '{ioctl0_reg[IOCTL_LO_ACT +: 2], ioctl0_reg[IOCTL_HI_ACT +: 2],
        buf_c ? ACT_NONE : ioctl1_reg[IOCTL_LO_ACT +: 2], buf_d ? ACT_NONE : ioctl1_reg[IOCTL_HI_ACT +: 2]};
    wire logic cutoff = (int_func == INTF_CUTOFF) & ~sync2_reg[3];

    logic [3:0] level_next;
    logic [3:0] oe_comb;
    always_comb begin
        level_next = level_reg;
        oe_comb = 4'h0;
        for (int i = 0; i < 4; i++) begin
            oe_comb[i] = (act[i] != ACT_NONE) & ~cutoff;
            if (tick_run & match[i]) begin
                case (toc_act_e'(act[i]))
                    ACT_LOW: level_next[i] = 1'b0;
                    ACT_HIGH: level_next[i] = 1'b1;
                    ACT_TOGGLE: level_next[i] = ~level_reg[i];
                    default: level_next[i] = level_reg[i];
                endcase
            end
        end
        if (wr_ctrl1) begin
            level_next = wd8[3:0];
        end
    end

    assign o_wave = '{level: level_reg, oe: oe_comb};

    logic [15:0] cnt_next;
    always_comb begin
        cnt_next = cnt_reg;
        if (wr_cnt) begin
            cnt_next = merge16(cnt_reg, wd16, {be1, be0});
        end else if (tick_run) begin
            if (match[0] & clear_on_a) begin
                cnt_next = 16'h0000;
            end else if (!stop_hit) begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
    end

    wire toc_evt_s evt_next = '{match: {4{tick_run}} & match, ovf: tick_run & (cnt_reg == CNT_TOP)};

    // ************************************************************
    // state registers
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pre_reg <= 5'h00;
            cnt_reg <= 16'h0000;
            level_reg <= 4'h0;
            evt_reg <= '0;
            int_req_reg <= 1'b0;
        end else begin
            pre_reg <= pre_reg + 5'h01;
            cnt_reg <= cnt_next;
            level_reg <= level_next;
            evt_reg <= evt_next;
            int_req_reg <= (int_func == INTF_IRQ) & sync3_reg[3] & ~sync2_reg[3];
        end
    end

    assign o_evt = evt_reg;
    assign o_int_req = int_req_reg;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_reg <= RST_MODE;
            ctrl1_reg <= RST_CTRL1;
            ctrl2_reg <= RST_CTRL2;
            ioctl0_reg <= RST_IOCTL;
            ioctl1_reg <= RST_IOCTL;
            sts_reg <= 5'h00;
        end else begin
            if (wr_mode) begin
                mode_reg <= wd8;
            end else if (stop_hit) begin
                mode_reg[MODE_RUN] <= 1'b0;
            end
            if (wr_ctrl1) begin
                ctrl1_reg <= wd8;
            end
            if (wr_ctrl2) begin
                ctrl2_reg <= wd8;
            end
            if (wr_io0) begin
                ioctl0_reg <= wd8;
            end
            if (wr_io1) begin
                ioctl1_reg <= wd8;
            end
            // set wins over write-one-to-clear
            sts_reg <= (sts_reg & ~({5{wr_sts}} & wd8[4:0])) | evt_next;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < 4; i++) begin
                cmp_reg[i] <= RST_CMP;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_cmp[i]) begin
                    cmp_reg[i] <= merge16(cmp_reg[i], wd16, {be1, be0});
                end else if (i < 2 && tick_run && match[i] && buf_on[i % 2]) begin
                    cmp_reg[i] <= cmp_reg[(i + 2) % 4];
                end
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_tick_run;
        tick && run;
    endsequence

    sequence s_read_count;
        i_avs_read && !o_avs_waitrequest && i_avs_address == IDX_COUNT;
    endsequence

    a_read_count: assert property (s_read_count |-> o_avs_readdata[15:0] == $past(cnt_reg))
        else $error("count read returned wrong value");
    a_write_count: assert property (wr_cnt && be0 && be1 |=> cnt_reg == $past(wd16))
        else $error("count write not loaded");
    a_clear_on_a: assert property (s_tick_run and (match[0] && clear_on_a && !wr_cnt) |=> cnt_reg == 16'h0000)
        else $error("counter not cleared on compare A");
    a_count_step: assert property (s_tick_run and (!match[0] && !wr_cnt) |=> cnt_reg == $past(cnt_reg) + 16'h0001)
        else $error("counter did not step by one");
    a_wrap_overflow: assert property (s_tick_run and (cnt_reg == CNT_TOP && !wr_cnt && !match[0])
        |=> cnt_reg == 16'h0000 && o_evt.ovf)
        else $error("overflow wrap or request missing");
    a_stopped_hold: assert property (!run && !wr_cnt |=> $stable(cnt_reg))
        else $error("counter moved while stopped");
    a_stop_match: assert property (stop_hit && !wr_mode |=> !run ##1 $stable(level_reg) || wr_ctrl1)
        else $error("counter kept running after compare A stop");
    a_init_level: assert property (wr_ctrl1 |=> level_reg == $past(wd8[3:0]))
        else $error("initial level not driven on control write");
    a_match_high: assert property (s_tick_run and (match[1] && act[1] == ACT_HIGH && !wr_ctrl1)
        |=> level_reg[1] && o_evt.match[1])
        else $error("pin B not driven high on match");
    a_cutoff_off: assert property (cutoff |-> o_wave.oe == 4'h0)
        else $error("pins driven during forced cutoff");
    a_no_pin_count: assert property (s_tick_run and (match[0] && act[0] == ACT_NONE) |=> o_evt.match[0])
        else $error("internal match lost with pin disabled");
    a_buffer_move: assert property (s_tick_run and (match[0] && buf_c && !wr_cmp[0])
        |=> cmp_reg[0] == $past(cmp_reg[2]))
        else $error("buffered compare value not moved to A");
endmodule

// [bench/toc_load_model.sv]
// loads on the four wave pins plus the external count clock source
// assumes the timer's pin carrier and the bench clock
module toc_load_model
    import toc_pkg::*;
(
    input wire logic i_clk, // bench clock
    input wire toc_wave_s i_wave, // pin levels and enables
    input wire logic i_ext_en, // let the external clock run
    output logic o_ext_clk, // external count clock
    output logic [3:0] o_pin_line // resolved pin levels
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div_reg = 3'h0;
    // a released pin is pulled up
    assign o_pin_line = (i_wave.oe & i_wave.level) | ~i_wave.oe;
    // clock stands low while disabled
    assign o_ext_clk = div_reg[2] & i_ext_en;
    always @(posedge i_clk) begin
        if (i_ext_en) begin
            div_reg <= div_reg + 3'h1;
        end
    end
endmodule

// [bench/tb_top.sv]
// self-checking bench of the output compare timer
// assumes toc_top, the load model and a 20 MHz clock
module tb_top
    import toc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic wr; logic [9:0] a; logic [15:0] d;} toc_row_s;
    localparam logic [3:0] INIT_LV = 4'h5;
    localparam logic [3:0] AFTER_LV = 4'hA;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [9:0] i_avs_address = 10'h000;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [3:0] i_avs_byteenable = 4'h3;
    logic [31:0] i_avs_writedata = 32'h0;
    logic i_int_pin_b = 1'b1;
    logic osc_clk = 1'b0;
    logic ext_en = 1'b0;
    logic ext_clk;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    toc_wave_s o_wave;
    toc_evt_s o_evt;
    logic o_int_req;
    logic [3:0] pin_line;
    logic [3:0] prev_level = 4'h0;
    logic [3:0] seen = 4'hF;
    logic [3:0] lv;
    logic [15:0] rd;
    logic [15:0] rd2;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    int last_a = -1;
    int per_a = 0;
    int a_cnt = 0;
    int ovf_cnt = 0;
    int irq_cnt = 0;
    int exp_src[8] = '{128, 64, 32, 16, 4, 16, 16, 16};
    toc_row_s rows[16] = '{
        '{0, IDX_CTRL1, 16'h0000}, '{0, IDX_MODE, 16'h0000}, '{0, IDX_IOCTL0, 16'h0088},
        '{0, IDX_IOCTL1, 16'h0088}, '{0, IDX_CTRL2, 16'h0000}, '{0, IDX_CMP_A, 16'hFFFF},
        '{0, IDX_CMP_D, 16'hFFFF}, '{0, IDX_COUNT, 16'h0000}, '{0, IDX_STATUS, 16'h0000},
        '{1, 10'h3FF, 16'h1234}, '{0, 10'h3FF, 16'h0000}, '{1, IDX_IOCTL0, 16'h0000},
        '{0, IDX_IOCTL0, 16'h0080}, '{1, IDX_COUNT, 16'h1234}, '{0, IDX_COUNT, 16'h1234},
        '{1, IDX_CTRL1, 16'h00A5}};

    toc_top DUT (.i_clk, .i_rst_b, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_byteenable,
        .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_ext_count_clock_pin(ext_clk),
        .i_osc_40mhz_clock(osc_clk), .i_fast_osc_clock(osc_clk), .i_int_pin_b, .o_wave, .o_evt, .o_int_req);
    toc_load_model u_load (.i_clk, .i_wave(o_wave), .i_ext_en(ext_en), .o_ext_clk(ext_clk), .o_pin_line(pin_line));

    always #25 i_clk = ~i_clk;
    always #200 osc_clk = ~osc_clk;

    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v, input string what);
        compares++;
        if (seen_v !== exp_v) begin
            errors++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen_v, exp_v);
        end
    endtask

    task automatic bus(input logic wr, input logic [9:0] a, input logic [15:0] d, output logic [15:0] r);
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_write <= wr;
        i_avs_read <= ~wr;
        i_avs_writedata <= {16'h0, d};
        do begin
            @(posedge i_clk);
        end while (o_avs_waitrequest !== 1'b0);
        r = o_avs_readdata[15:0];
        check(o_avs_readdata[31:16], 16'h0000, "upper data bits");
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        logic [15:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rdchk(input logic [9:0] a, input logic [15:0] e, input string w);
        logic [15:0] x;
        bus(1'b0, a, 16'h0, x);
        check(x, e, w);
    endtask

    // ****************************************
    // event monitor
    // ****************************************
    always @(negedge i_clk) begin
        cyc++;
        for (int i = 0; i < 4; i++) begin
            if (o_evt.match[i] === 1'b1 && !seen[i]) begin
                seen[i] = 1'b1;
                check(16'(prev_level[i]), 16'(INIT_LV[i]), "level before match");
                check(16'(o_wave.level[i]), 16'(AFTER_LV[i]), "level after match");
            end
        end
        if (o_evt.match[0] === 1'b1) begin
            a_cnt++;
            if (last_a >= 0) per_a = cyc - last_a;
            last_a = cyc;
        end
        if (o_evt.ovf === 1'b1) ovf_cnt++;
        if (o_int_req === 1'b1) irq_cnt++;
        prev_level = o_wave.level;
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        give_verdict();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst_b <= 1'b1;
        foreach (rows[i]) begin
            bus(rows[i].wr, rows[i].a, rows[i].wr ? rows[i].d : 16'h0, rd);
            if (!rows[i].wr) check(rd, rows[i].d, "register");
        end
        wr(IDX_IOCTL0, 16'h0023);
        wr(IDX_IOCTL1, 16'h0021);
        wr(IDX_CTRL1, 16'h0085);
        @(negedge i_clk);
        check({12'h0, pin_line}, 16'h0005, "initial levels");
        check({12'h0, o_wave.oe}, 16'h000F, "pins enabled");
        wr(IDX_CMP_A, 16'h0009);
        wr(IDX_CMP_B, 16'h0003);
        wr(IDX_CMP_C, 16'h0005);
        wr(IDX_CMP_D, 16'h0007);
        wr(IDX_COUNT, 16'h0000);
        seen = 4'h0;
        wr(IDX_MODE, 16'h0080);
        repeat (60) @(posedge i_clk);
        bus(1'b0, IDX_COUNT, 16'h0, rd);
        check(16'(rd <= 16'h0009), 16'h1, "count below A");
        wr(IDX_MODE, 16'h0000);
        @(negedge i_clk);
        check(16'(per_a), 16'd10, "period A plus one");
        check(16'(seen), 16'h000F, "all matched");
        check({13'h0, pin_line[3:1]}, 16'h0005, "levels after match");
        lv = pin_line;
        bus(1'b0, IDX_COUNT, 16'h0, rd);
        repeat (20) @(posedge i_clk);
        bus(1'b0, IDX_COUNT, 16'h0, rd2);
        check(rd2, rd, "count held");
        check({12'h0, pin_line}, {12'h0, lv}, "pins held");
        wr(IDX_CTRL1, 16'h0005);
        wr(IDX_COUNT, 16'hFFF0);
        ovf_cnt = 0;
        wr(IDX_MODE, 16'h0080);
        repeat (30) @(posedge i_clk);
        wr(IDX_MODE, 16'h0000);
        check(16'(ovf_cnt), 16'h1, "one overflow");
        rdchk(IDX_STATUS, 16'h001F, "status flags set");
        wr(IDX_STATUS, 16'h001F);
        rdchk(IDX_STATUS, 16'h0000, "status flags cleared");
        wr(IDX_CTRL1, 16'h0085);
        wr(IDX_CMP_C, 16'h0004);
        wr(IDX_COUNT, 16'h0000);
        wr(IDX_MODE, 16'h00A0);
        @(negedge i_clk);
        check(16'(o_wave.oe[2]), 16'h0, "buffered pin released");
        repeat (15) @(posedge i_clk);
        wr(IDX_MODE, 16'h0020);
        rdchk(IDX_CMP_A, 16'h0004, "buffer moved to A");
        wr(IDX_IOCTL0, 16'h0000);
        wr(IDX_IOCTL1, 16'h0000);
        @(negedge i_clk);
        check({12'h0, o_wave.oe}, 16'h0000, "all pins off");
        wr(IDX_CTRL2, 16'h0020);
        wr(IDX_COUNT, 16'h0000);
        a_cnt = 0;
        wr(IDX_MODE, 16'h0080);
        repeat (30) @(posedge i_clk);
        rdchk(IDX_MODE, 16'h0000, "run cleared at match");
        rdchk(IDX_COUNT, 16'h0000, "count cleared and held");
        check(16'(a_cnt), 16'h1, "internal match");
        wr(IDX_IOCTL0, 16'h0023);
        wr(IDX_CTRL2, 16'h0001);
        i_int_pin_b <= 1'b0;
        repeat (4) @(posedge i_clk);
        check(16'({o_wave.oe, pin_line}), 16'h000F, "cutoff");
        i_int_pin_b <= 1'b1;
        repeat (4) @(posedge i_clk);
        check(16'(o_wave.oe), 16'h3, "cutoff lifted");
        for (int m = 2; m >= 0; m -= 2) begin
            wr(IDX_CTRL2, 16'(m));
            irq_cnt = 0;
            i_int_pin_b <= 1'b0;
            repeat (4) @(posedge i_clk);
            i_int_pin_b <= 1'b1;
            repeat (6) @(posedge i_clk);
            check(16'(irq_cnt), 16'(m / 2), "pin interrupt");
        end
        for (int c = 0; c < 8; c++) begin
            wr(IDX_CTRL1, 16'(c << 4));
            wr(IDX_COUNT, 16'h0000);
            ext_en <= (c == 5);
            wr(IDX_MODE, 16'h0080);
            repeat (128) @(posedge i_clk);
            wr(IDX_MODE, 16'h0000);
            bus(1'b0, IDX_COUNT, 16'h0, rd);
            check(16'(rd >= exp_src[c] - 1 && rd <= exp_src[c] + 4), 16'h1, "source rate");
        end
        // reset in mid-run
        wr(IDX_MODE, 16'h0080);
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(negedge i_clk);
        check(16'(o_wave.oe), 16'h0000, "pins released after reset");
        rdchk(IDX_MODE, 16'h0000, "run cleared by reset");
        rdchk(IDX_COUNT, 16'h0000, "count cleared by reset");
        give_verdict();
    end
endmodule
